// ==== include/ds0_dataport_pkg.sv ====
// Constants and types of the four-port dataport block.
// Assumes a 200 MHz reference clock and a WAN time-slot bus clocked by its own link clock.
package ds0_dataport_pkg;

    // ----------
    // Sizes
    // ----------
    localparam int NUM_PORTS = 4;
    localparam int LINK_W = 3;
    localparam int SLOT_W = 5;

    // ----------
    // Timing
    // ----------
    localparam int CLK_HZ = 200_000_000;
    localparam int BIT_RATE_HZ = 64_000;
    localparam int BYTE_RATE_HZ = 8_000;
    localparam int BIT_DIV = CLK_HZ / BIT_RATE_HZ;
    localparam int BIT_HALF = BIT_DIV / 2;
    localparam int BIT_QTR = BIT_DIV / 4;
    localparam int BIT_3QTR = (3 * BIT_DIV) / 4;
    localparam int DIV_W = 12;
    localparam int LOOP_TIMEOUT_MIN = 10;
    localparam int LOOP_TIMEOUT_BYTES_DFLT = LOOP_TIMEOUT_MIN * 60 * BYTE_RATE_HZ;
    localparam int TIMEOUT_W = 23;
    localparam logic [3:0] DET_REPEAT = 4'h8;

    // ----------
    // Slot ranges
    // ----------
    localparam logic [SLOT_W-1:0] T1_MAX_SLOT = 5'h18;
    localparam logic [SLOT_W-1:0] E1_MAX_SLOT = 5'h1F;
    localparam logic [SLOT_W-1:0] E1_SIG_SLOT = 5'h10;

    // ----------
    // Loop codes (byte patterns, arbitrary values)
    // ----------
    localparam logic [7:0] CODE_OCU = 8'h2A;
    localparam logic [7:0] CODE_DSU = 8'h2C;
    localparam logic [7:0] CODE_CSU = 8'h28;
    localparam logic [7:0] CODE_DS0 = 8'h33;
    localparam logic [7:0] CODE_DOWN = 8'h24;

    // ----------
    // Modes and selections
    // ----------
    typedef enum logic [1:0] {MODE_DATAPORT, MODE_CONTRA, MODE_CODIR} mode_t;
    typedef enum logic [1:0] {LOOP_OFF, LOOP_TO_EQUIP, LOOP_TO_NET} loop_sel_t;
    typedef enum logic [2:0] {GEN_OFF, GEN_OCU, GEN_DSU, GEN_CSU, GEN_DS0} gen_sel_t;
    typedef enum logic [1:0] {DETECT_OFF, DETECT_ENABLE, DETECT_WITH_TIMEOUT} det_sel_t;

    // Per-port slot claim passed to the link side
    typedef struct packed {
        logic claim;
        logic [LINK_W-1:0] link;
        logic [SLOT_W-1:0] slot;
        logic net_loop;
    } cfg_t;

endpackage

// ==== verilog/ds0_dataport_interface.sv ====
// Four-port 64 kbps dataport: equipment-side clocks/data and WAN time-slot bus access.
// Assumes static per-port settings on plain ports and a link-clocked slot bus.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Each port moves 64 kbps to one slot
// R2: Dataport mode gives 64k bit, 8k byte clocks
// R3: Standby ports claim no slot at all
// R4: WAN destination routes data to chosen link slot
// R5: No destination forces slot to not applicable
// R6: Slots 1-24 T1, 1-31 E1, 16 excluded; code excludes 16 only when link_sig_in_slot16 is set for the link
// R7: Ports assigned independently to links and slots
// R8: Dataport shares one bit, one byte clock
// R9: Dataport on one sets all; G.703 moves others
// R10: Contradirectional: card sources both clocks
// R11: Codirectional: composite signal, timing from data
// R12: Internal drives clocks; external accepts them
// R13: Clock source is common to all ports
// R14: G.703 modes make clock source not applicable
// R15: Local loop: off, toward equipment, toward network
// R16: Generation sends selected latching loop code
// R17: Code generation only in dataport mode
// R18: Detection off ignores codes; latches until down
// R19: Timeout setting releases latch after 10 minutes
// R20: Code detection only in dataport mode
// R21: Reset gives standby, dataport, internal, all off
// R22: Latched loop returns network data to network
module ds0_dataport_interface #(
    parameter int unsigned LOOP_TIMEOUT_BYTES = ds0_dataport_pkg::LOOP_TIMEOUT_BYTES_DFLT
) (
    // Clocks, reset, enable
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Per-port settings
    input wire logic [3:0] port_active,
    input wire logic [3:0] destination_select,
    input wire logic [3:0][ds0_dataport_pkg::LINK_W-1:0] wan_link,
    input wire logic [3:0][ds0_dataport_pkg::SLOT_W-1:0] slot_number,
    input wire logic [3:0][1:0] local_loop_select,
    input wire logic [3:0][2:0] loop_code_generate,
    input wire logic [3:0][1:0] loop_code_detect,
    // Link framing per WAN link
    input wire logic [7:0] link_is_e1,
    input wire logic [7:0] link_sig_in_slot16,
    // Mode and clock source writes
    input wire logic mode_set,
    input wire logic [1:0] mode_set_port,
    input wire logic [1:0] mode_set_value,
    input wire logic clk_src_set,
    input wire logic clk_src_external,
    // Status
    output logic [3:0][1:0] port_mode,
    output logic clk_external,
    output logic [3:0] clk_source_na,
    output logic [3:0][ds0_dataport_pkg::SLOT_W-1:0] slot_assigned,
    output logic [3:0] loop_latched,
    // Equipment pins
    output logic [3:0] data_to_equipment,
    input wire logic [3:0] data_from_equipment,
    output logic [3:0] xmt_clk_out,
    output logic [3:0] rcv_clk_out,
    output logic [3:0] bit_clk_o,
    output logic [3:0] bit_clk_oe,
    input wire logic [3:0] bit_clk_i,
    output logic [3:0] byte_clk_o,
    output logic [3:0] byte_clk_oe,
    input wire logic [3:0] byte_clk_i,
    // WAN time-slot bus (link_clk domain)
    input wire logic tsb_valid,
    input wire logic [ds0_dataport_pkg::LINK_W-1:0] tsb_link,
    input wire logic [ds0_dataport_pkg::SLOT_W-1:0] tsb_slot,
    input wire logic [7:0] tsb_rx_byte,
    output logic [7:0] tsb_tx_byte,
    output logic tsb_tx_claim
);
    import ds0_dataport_pkg::*;

    // ----------
    // State types
    // ----------
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [2:0] bidx;
        logic int_bit;
        mode_t [3:0] mode;
        logic clk_ext;
        logic [3:0][1:0] din_s;
        logic [3:0][1:0] bclk_s;
        logic [3:0][1:0] yclk_s;
        logic [3:0] bclk_d;
        logic [3:0] cdin_d;
        logic [3:0][2:0] rtg_s;
        logic [3:0][DIV_W-1:0] rph;
        logic [3:0][7:0] rx_sh;
        logic [3:0][2:0] rx_idx;
        logic [3:0][7:0] eq_last;
        logic [3:0][7:0] tx_sh;
        logic [3:0][2:0] tx_idx;
        logic [3:0] tx_bit;
        logic [3:0][7:0] net_hold;
        logic [3:0] ttg;
        logic [3:0][7:0] from_net;
        logic [3:0][3:0] det_cnt;
        logic [3:0] latched;
        logic [3:0][TIMEOUT_W-1:0] to_cnt;
        cfg_t [3:0] cfg;
        logic [3:0] clk_na;
        logic [3:0][SLOT_W-1:0] slot_eff;
        logic [3:0] dte_dat;
        logic [3:0] xclk;
        logic [3:0] rclk;
        logic [3:0] bit_o;
        logic [3:0] bit_oe;
        logic [3:0] byte_o;
        logic [3:0] byte_oe;
    } ref_state_t;

    typedef struct packed {
        logic [1:0] en_s;
        cfg_t [3:0] cfg_s1;
        cfg_t [3:0] cfg_s2;
        logic [3:0][2:0] ttg_s;
        logic [3:0][7:0] tx_hold;
        logic [3:0][7:0] rx_hold;
        logic [3:0] rtg;
        logic [7:0] tx_byte;
        logic tx_claim;
    } link_state_t;

    ref_state_t rf_ff;
    ref_state_t nxt_rf;
    link_state_t lk_ff;
    link_state_t nxt_lk;

    // ----------
    // Decoding helpers
    // ----------
    function automatic logic [7:0] code_of(input logic [2:0] sel);
        unique case (sel)
            GEN_OCU: code_of = CODE_OCU;
            GEN_DSU: code_of = CODE_DSU;
            GEN_CSU: code_of = CODE_CSU;
            GEN_DS0: code_of = CODE_DS0;
            default: code_of = CODE_DOWN;
        endcase
    endfunction

    function automatic logic slot_ok(input logic [SLOT_W-1:0] s, input logic e1, input logic sig16);
        if (s == '0) begin
            slot_ok = 1'b0;
        end else if (e1) begin
            slot_ok = (s <= E1_MAX_SLOT) && !(sig16 && s == E1_SIG_SLOT);
        end else begin
            slot_ok = (s <= T1_MAX_SLOT);
        end
    endfunction

    // ----------
    // Reference clock domain
    // ----------
    always_comb begin
        logic int_tick;
        logic dp;
        logic ext;
        logic tick;
        logic rtick;
        logic byte_start;
        logic din;
        logic [2:0] idx;
        logic [7:0] sh;
        logic [7:0] nb;
        logic is_up;
        nxt_rf = rf_ff;
        int_tick = 1'b0;
        dp = 1'b0;
        ext = 1'b0;
        tick = 1'b0;
        rtick = 1'b0;
        byte_start = 1'b0;
        din = 1'b0;
        idx = '0;
        sh = '0;
        nb = '0;
        is_up = 1'b0;
        if (clk_en) begin
            // R2: internal 64 kHz bit, 8 kHz byte timing
            int_tick = (rf_ff.div == DIV_W'(BIT_DIV - 1));
            nxt_rf.div = int_tick ? '0 : rf_ff.div + 1'b1;
            nxt_rf.int_bit = (nxt_rf.div < DIV_W'(BIT_HALF));
            if (int_tick) begin
                nxt_rf.bidx = rf_ff.bidx + 1'b1;
            end
            // R9: dataport write sets every port; G.703 write sets one port, moves dataport ports to contra
            if (mode_set && mode_set_value != 2'h3) begin
                for (int q = 0; q < NUM_PORTS; q++) begin
                    if (mode_t'(mode_set_value) == MODE_DATAPORT) begin
                        nxt_rf.mode[q] = MODE_DATAPORT;
                    end else if (q == int'(mode_set_port)) begin
                        nxt_rf.mode[q] = mode_t'(mode_set_value);
                    end else if (rf_ff.mode[q] == MODE_DATAPORT) begin
                        nxt_rf.mode[q] = MODE_CONTRA;
                    end
                end
            end
            // R13: single clock source for the card
            if (clk_src_set) begin
                nxt_rf.clk_ext = clk_src_external;
            end
            for (int p = 0; p < NUM_PORTS; p++) begin
                nxt_rf.din_s[p] = {rf_ff.din_s[p][0], data_from_equipment[p]};
                nxt_rf.bclk_s[p] = {rf_ff.bclk_s[p][0], bit_clk_i[p]};
                nxt_rf.yclk_s[p] = {rf_ff.yclk_s[p][0], byte_clk_i[p]};
                nxt_rf.bclk_d[p] = rf_ff.bclk_s[p][1];
                nxt_rf.cdin_d[p] = rf_ff.din_s[p][1];
                din = rf_ff.din_s[p][1];
                dp = (rf_ff.mode[p] == MODE_DATAPORT);
                ext = dp && rf_ff.clk_ext;
                // R12: external bit clock taken on synchronised rising edge, byte clock as synchronised level
                tick = ext ? (rf_ff.bclk_s[p][1] && !rf_ff.bclk_d[p]) : int_tick;
                byte_start = ext ? rf_ff.yclk_s[p][1] : (rf_ff.bidx == 3'h7);
                // R11: recover bit timing from mid-bit transitions
                nxt_rf.rph[p] = (rf_ff.rph[p] == DIV_W'(BIT_DIV - 1)) ? '0 : rf_ff.rph[p] + 1'b1;
                if (din != rf_ff.cdin_d[p] && rf_ff.rph[p] > DIV_W'(BIT_QTR)
                        && rf_ff.rph[p] < DIV_W'(BIT_3QTR)) begin
                    nxt_rf.rph[p] = DIV_W'(BIT_HALF);
                end
                rtick = (rf_ff.rph[p] == DIV_W'(BIT_QTR));
                // R1: assemble bytes from the equipment
                if (rf_ff.mode[p] == MODE_CODIR ? rtick : tick) begin
                    idx = (dp && byte_start) ? 3'h0 : rf_ff.rx_idx[p];
                    sh = {rf_ff.rx_sh[p][6:0], din};
                    nxt_rf.rx_sh[p] = sh;
                    nxt_rf.rx_idx[p] = idx + 1'b1;
                    if (idx == 3'h7) begin
                        nxt_rf.eq_last[p] = sh;
                        // R16: loop code replaces data
                        // R17: generation in dataport only
                        if (dp && gen_sel_t'(loop_code_generate[p]) != GEN_OFF) begin
                            nxt_rf.net_hold[p] = code_of(loop_code_generate[p]);
                        end else begin
                            nxt_rf.net_hold[p] = sh;
                        end
                        nxt_rf.ttg[p] = !rf_ff.ttg[p];
                    end
                end
                // R1: serialise bytes toward the equipment
                if (tick) begin
                    idx = (dp && byte_start) ? 3'h0 : rf_ff.tx_idx[p];
                    nxt_rf.tx_idx[p] = idx + 1'b1;
                    if (idx == 3'h0) begin
                        // R15: loop toward equipment
                        nb = (loop_sel_t'(local_loop_select[p]) == LOOP_TO_EQUIP) ? rf_ff.eq_last[p]
                            : rf_ff.from_net[p];
                    end else begin
                        nb = rf_ff.tx_sh[p];
                    end
                    nxt_rf.tx_bit[p] = nb[7];
                    nxt_rf.tx_sh[p] = {nb[6:0], 1'b0};
                end
                // Bytes arriving from the link side
                nxt_rf.rtg_s[p] = {rf_ff.rtg_s[p][1:0], lk_ff.rtg[p]};
                if (rf_ff.rtg_s[p][2] != rf_ff.rtg_s[p][1]) begin
                    nb = lk_ff.rx_hold[p];
                    nxt_rf.from_net[p] = nb;
                    is_up = (nb == CODE_OCU) || (nb == CODE_DSU) || (nb == CODE_CSU) || (nb == CODE_DS0);
                    // R18: latch on repeated loop-up code
                    if (!rf_ff.latched[p]) begin
                        nxt_rf.det_cnt[p] = is_up ? rf_ff.det_cnt[p] + 1'b1 : '0;
                        if (is_up && rf_ff.det_cnt[p] == DET_REPEAT - 1'b1) begin
                            nxt_rf.latched[p] = 1'b1;
                            nxt_rf.det_cnt[p] = '0;
                            nxt_rf.to_cnt[p] = '0;
                        end
                    end else begin
                        nxt_rf.det_cnt[p] = (nb == CODE_DOWN) ? rf_ff.det_cnt[p] + 1'b1 : '0;
                        nxt_rf.to_cnt[p] = rf_ff.to_cnt[p] + 1'b1;
                        if (nb == CODE_DOWN && rf_ff.det_cnt[p] == DET_REPEAT - 1'b1) begin
                            nxt_rf.latched[p] = 1'b0;
                            nxt_rf.det_cnt[p] = '0;
                        end
                        // R19: self-release after timeout
                        if (det_sel_t'(loop_code_detect[p]) == DETECT_WITH_TIMEOUT
                                && rf_ff.to_cnt[p] == TIMEOUT_W'(LOOP_TIMEOUT_BYTES - 1)) begin
                            nxt_rf.latched[p] = 1'b0;
                            nxt_rf.det_cnt[p] = '0;
                        end
                    end
                end
                // R20: detection off or G.703 drops latch
                if (!dp || det_sel_t'(loop_code_detect[p]) == DETECT_OFF) begin
                    nxt_rf.latched[p] = 1'b0;
                    nxt_rf.det_cnt[p] = '0;
                end
                // R3: standby claims nothing
                // R4: WAN destination claims link and slot
                // R6: slot range per link type
                // R7: each port set on its own
                nxt_rf.cfg[p].claim = port_active[p] && destination_select[p]
                    && slot_ok(slot_number[p], link_is_e1[wan_link[p]], link_sig_in_slot16[wan_link[p]]);
                nxt_rf.cfg[p].link = wan_link[p];
                nxt_rf.cfg[p].slot = slot_number[p];
                // R22: latched loop returns network data
                nxt_rf.cfg[p].net_loop = (loop_sel_t'(local_loop_select[p]) == LOOP_TO_NET)
                    || rf_ff.latched[p];
                // R5: no destination, slot not applicable
                nxt_rf.slot_eff[p] = nxt_rf.cfg[p].claim ? slot_number[p] : '0;
                // R14: clock source void in G.703 modes
                nxt_rf.clk_na[p] = !dp;
                // R11: biphase composite in codirectional mode
                nxt_rf.dte_dat[p] = (rf_ff.mode[p] == MODE_CODIR) ? (rf_ff.tx_bit[p] ^ !rf_ff.int_bit)
                    : rf_ff.tx_bit[p];
                // R10: card sources both clocks
                nxt_rf.xclk[p] = (rf_ff.mode[p] == MODE_CONTRA) && rf_ff.int_bit;
                nxt_rf.rclk[p] = (rf_ff.mode[p] == MODE_CONTRA) && rf_ff.int_bit;
                // R8: shared bit and byte clocks
                // R12: driven only when internal
                nxt_rf.bit_oe[p] = dp && !rf_ff.clk_ext;
                nxt_rf.byte_oe[p] = dp && !rf_ff.clk_ext;
                nxt_rf.bit_o[p] = dp && !rf_ff.clk_ext && rf_ff.int_bit;
                nxt_rf.byte_o[p] = dp && !rf_ff.clk_ext && (rf_ff.bidx == 3'h0);
            end
        end
    end

    // R21: all-zero reset is standby, dataport, internal, off
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rf_ff <= '0;
        end else begin
            rf_ff <= nxt_rf;
        end
    end

    // ----------
    // Link clock domain
    // ----------
    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.en_s = {lk_ff.en_s[0], clk_en};
        if (lk_ff.en_s[1]) begin
            nxt_lk.cfg_s1 = rf_ff.cfg;
            nxt_lk.cfg_s2 = lk_ff.cfg_s1;
            nxt_lk.tx_claim = 1'b0;
            nxt_lk.tx_byte = '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                nxt_lk.ttg_s[p] = {lk_ff.ttg_s[p][1:0], rf_ff.ttg[p]};
                if (lk_ff.ttg_s[p][2] != lk_ff.ttg_s[p][1]) begin
                    nxt_lk.tx_hold[p] = rf_ff.net_hold[p];
                end
            end
            // R4: answer only the port's own link and slot
            if (tsb_valid) begin
                for (int p = NUM_PORTS - 1; p >= 0; p--) begin
                    if (lk_ff.cfg_s2[p].claim && lk_ff.cfg_s2[p].link == tsb_link
                            && lk_ff.cfg_s2[p].slot == tsb_slot) begin
                        nxt_lk.tx_claim = 1'b1;
                        // R15: loop toward network
                        // R22: latched loop back to network
                        nxt_lk.tx_byte = lk_ff.cfg_s2[p].net_loop ? tsb_rx_byte : lk_ff.tx_hold[p];
                        nxt_lk.rx_hold[p] = tsb_rx_byte;
                        nxt_lk.rtg[p] = !lk_ff.rtg[p];
                    end
                end
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_ff <= '0;
        end else begin
            lk_ff <= nxt_lk;
        end
    end

    // ----------
    // Outputs
    // ----------
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_mode[p] = rf_ff.mode[p];
        end
    end
    assign clk_external = rf_ff.clk_ext;
    assign clk_source_na = rf_ff.clk_na;
    assign slot_assigned = rf_ff.slot_eff;
    assign loop_latched = rf_ff.latched;
    assign data_to_equipment = rf_ff.dte_dat;
    assign xmt_clk_out = rf_ff.xclk;
    assign rcv_clk_out = rf_ff.rclk;
    assign bit_clk_o = rf_ff.bit_o;
    assign bit_clk_oe = rf_ff.bit_oe;
    assign byte_clk_o = rf_ff.byte_o;
    assign byte_clk_oe = rf_ff.byte_oe;
    assign tsb_tx_byte = lk_ff.tx_byte;
    assign tsb_tx_claim = lk_ff.tx_claim;

endmodule // ds0_dataport_interface

`default_nettype wire

// ==== sim/ds0_dataport_chk.sv ====
// Checker of the dataport block's ref_clk-side port relations.
// Assumes it is bound onto the top module with every port connected by name.
`timescale 1ns/1ps
`default_nettype none
module ds0_dataport_chk (
    // Clock, reset, settings
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [3:0] port_active,
    input wire logic [3:0] destination_select,
    input wire logic [3:0][1:0] loop_code_detect,
    input wire logic mode_set,
    input wire logic [1:0] mode_set_port,
    input wire logic [1:0] mode_set_value,
    input wire logic clk_src_set,
    input wire logic clk_src_external,
    // Status
    input wire logic [3:0][1:0] port_mode,
    input wire logic clk_external,
    input wire logic [3:0][ds0_dataport_pkg::SLOT_W-1:0] slot_assigned,
    input wire logic [3:0] loop_latched,
    input wire logic [3:0] bit_clk_oe,
    input wire logic [3:0] xmt_clk_out
);
    import ds0_dataport_pkg::*;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    standby_no_slot_a: assert property ((!port_active[3])[*3] |-> slot_assigned[3] == 5'h00)
        else $error("standby port holds a slot");
    none_no_slot_a: assert property ((!destination_select[2])[*3] |-> slot_assigned[2] == 5'h00)
        else $error("port without destination holds a slot");
    mode_all_dp_a: assert property (mode_set && clk_en && mode_set_value == 2'h0 |=> port_mode == 8'h00)
        else $error("dataport write did not reach all ports");
    mode_one_port_a: assert property (mode_set && clk_en && mode_set_value inside {2'h1, 2'h2}
        |=> port_mode[$past(mode_set_port)] == $past(mode_set_value)) else $error("mode write lost");
    clk_src_common_a: assert property (clk_src_set && clk_en |=> clk_external == $past(clk_src_external))
        else $error("clock source write lost");
    ext_no_drive_a: assert property (clk_external[*3] |-> bit_clk_oe == 4'h0)
        else $error("bit clock driven under external clocking");
    contra_only_clk_a: assert property ((port_mode[0] != 2'h1)[*3] |-> !xmt_clk_out[0])
        else $error("transmit clock outside contradirectional mode");
    detect_off_a: assert property ((loop_code_detect[0] == 2'h0)[*3] |-> !loop_latched[0])
        else $error("loop latched with detection off");
endmodule // ds0_dataport_chk
`default_nettype wire

// ==== sim/dte_model.sv ====
// Partner model of the equipment: data, and clocks when the card does not drive them.
// Assumes the 200 MHz ref_clk, so one bit lasts BIT_DIV cycles.
`timescale 1ns/1ps
`default_nettype none
module dte_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Clock pins
    input wire logic [3:0] bit_clk_o,
    input wire logic [3:0] bit_clk_oe,
    input wire logic [3:0] byte_clk_o,
    input wire logic [3:0] byte_clk_oe,
    output logic [3:0] bit_clk_i,
    output logic [3:0] byte_clk_i,
    // Data pin
    output logic [3:0] data_from_equipment
);
    import ds0_dataport_pkg::*;
    int cnt;
    logic [2:0] bidx;
    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    // shared clock drive
    assign bit_clk_i = (bit_clk_oe & bit_clk_o) | (~bit_clk_oe & {4{cnt < BIT_HALF}});
    assign byte_clk_i = (byte_clk_oe & byte_clk_o) | (~byte_clk_oe & {4{bidx == 3'h0}});
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            bidx <= 3'h0;
            data_from_equipment <= 4'h5;
        end else begin
            cnt <= (cnt == BIT_DIV - 1) ? 0 : cnt + 1;
            if (cnt == BIT_DIV - 1)
                bidx <= bidx + 3'h1;
            // New bit on the falling clock edge
            if (cnt == BIT_HALF)
                data_from_equipment <= {data_from_equipment[2:0], ~data_from_equipment[3] ^ data_from_equipment[0]};
        end
    end
endmodule // dte_model
`default_nettype wire

// ==== sim/test_ds0_dataport_interface.sv ====
// Testbench of the dataport block: slot claims, slot bus, clocks, modes, loop code generation.
// Assumes the equipment partner model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_ds0_dataport_interface;
    import ds0_dataport_pkg::*;
    logic ref_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, tsb_valid = 1'b0;
    logic mode_set = 1'b0, clk_src_set = 1'b0, clk_src_external = 1'b0, clk_external, tsb_tx_claim;
    logic [1:0] mode_set_port = 2'h0, mode_set_value = 2'h0;
    logic [3:0] port_active = 4'h7, destination_select = 4'hB, clk_source_na, loop_latched;
    logic [3:0] data_to_equipment, data_from_equipment, xmt_clk_out, rcv_clk_out;
    logic [3:0] bit_clk_o, bit_clk_oe, bit_clk_i, byte_clk_o, byte_clk_oe, byte_clk_i;
    logic [3:0][LINK_W-1:0] wan_link;
    logic [3:0][SLOT_W-1:0] slot_number, slot_assigned;
    logic [3:0][1:0] local_loop_select = '0, loop_code_detect = '0, port_mode;
    logic [3:0][2:0] loop_code_generate = {9'h000, GEN_DSU};
    logic [7:0] link_is_e1 = 8'h04, link_sig_in_slot16 = 8'h04, tsb_rx_byte = 8'h00, tsb_tx_byte;
    logic [LINK_W-1:0] tsb_link = '0;
    logic [SLOT_W-1:0] tsb_slot = '0;
    logic [4:0] corner [5] = '{5'h10, 5'h1F, 5'h18, 5'h19, 5'h00};
    logic [15:0] rnd = 16'h16FD;
    int fails = 0, checks_done = 0, cyc = 0, n;
    ds0_dataport_interface #(.LOOP_TIMEOUT_BYTES(20)) u_ds0_dataport_interface (.*);
    dte_model u_dte_model (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        #7.3;
        forever #16 link_clk = ~link_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [4:0] exp_slot(int p);
        logic e1;
        e1 = link_is_e1[wan_link[p]];
        if (!port_active[p] || !destination_select[p] || slot_number[p] == 5'h00
            || (e1 && link_sig_in_slot16[wan_link[p]] && slot_number[p] == E1_SIG_SLOT)
            || slot_number[p] > (e1 ? E1_MAX_SLOT : T1_MAX_SLOT))
            return 5'h00;
        return slot_number[p];
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic slot_io(input logic [2:0] lk, input logic [4:0] sl, input logic claim, do_byte, up = 1'b0);
        @(negedge link_clk);
        rnd = lfsr(rnd);
        {tsb_valid, tsb_link, tsb_slot, tsb_rx_byte} = {1'b1, lk, sl, up ? CODE_OCU : rnd[7:0]};
        @(negedge link_clk);
        tsb_valid = 1'b0;
        chk("claim", claim, tsb_tx_claim);
        if (do_byte)
            chk("tx byte", CODE_DSU, tsb_tx_byte);
    endtask
    task automatic mode_wr(input logic [1:0] p, v, input logic [7:0] exp);
        @(negedge ref_clk);
        {mode_set, mode_set_port, mode_set_value} = {1'b1, p, v};
        @(negedge ref_clk);
        mode_set = 1'b0;
        @(negedge ref_clk);
        chk("modes", exp, port_mode);
        for (int i = 0; i < 4; i++)
            chk("clock n/a", exp[2*i +: 2] != 2'h0, clk_source_na[i]);
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rnd = lfsr(rnd);
        wan_link = {3'h5, 3'h3, 3'h2, 2'h0, rnd[0]};
        slot_number = {5'h09, 5'h07, 5'h10, 5'(rnd[15:8] % 24 + 1)};
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("defaults", 32'h0000_0000, {port_mode, clk_external, loop_latched, clk_source_na});
        for (n = 0; n < 4; n++)
            chk("slot", exp_slot(n), slot_assigned[n]);
        for (n = 0; n < 5; n++) begin
            slot_number[1] = corner[n];
            link_is_e1[2] = n < 2;
            repeat (4) @(negedge ref_clk);
            chk("corner slot", exp_slot(1), slot_assigned[1]);
        end
        repeat (12) @(posedge link_clk);
        for (n = 0; n < 4; n++)
            slot_io(wan_link[n], slot_number[n], exp_slot(n) != 5'h00, 1'b0);
        @(posedge bit_clk_o[0]);
        n = cyc;
        @(posedge bit_clk_o[0]);
        chk("bit period", BIT_DIV, cyc - n);
        @(posedge byte_clk_o[0]);
        n = cyc;
        @(posedge byte_clk_o[0]);
        chk("byte period", 8 * BIT_DIV, cyc - n);
        chk("clock enables", 32'h0000_00FF, {bit_clk_oe, byte_clk_oe});
        slot_io(wan_link[0], slot_number[0], 1'b1, 1'b1);
        mode_wr(2'h2, 2'h2, 8'h65);
        mode_wr(2'h0, 2'h3, 8'h65);
        mode_wr(2'h3, 2'h2, 8'hA5);
        mode_wr(2'h1, 2'h0, 8'h00);
        @(negedge ref_clk);
        {clk_src_set, clk_src_external} = 2'h3;
        @(negedge ref_clk);
        clk_src_set = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("external clock", 32'h0000_0010, {clk_external, bit_clk_oe});
        loop_code_detect[0] = 2'h2;
        repeat (8) slot_io(wan_link[0], slot_number[0], 1'b1, 1'b0, 1'b1);
        repeat (4) @(negedge link_clk);
        chk("latched", 1'b1, loop_latched[0]);
        slot_io(wan_link[0], slot_number[0], 1'b1, 1'b0);
        chk("looped byte", tsb_rx_byte, tsb_tx_byte);
        repeat (19) slot_io(wan_link[0], slot_number[0], 1'b1, 1'b0);
        repeat (4) @(negedge link_clk);
        chk("released", 1'b0, loop_latched[0]);
        conclude();
    end
endmodule // test_ds0_dataport_interface
bind ds0_dataport_interface ds0_dataport_chk u_ds0_dataport_chk (.*);
`default_nettype wire
